//--- tmo_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tmo_timer
	import tmo_pkg::*;
(
	input  wire logic              mclk_in,
	input  wire logic              srst_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] wr_data_in,
	input  wire logic              wr_en_in,
	input  wire logic              rd_en_in,
	output logic      [DATA_W-1:0] rd_data_out,
	input  wire logic              ext_trigger_in,
	output logic                   half_rate_output_out,
	output logic      [2:0]        channel_pulse_output_out,
	output logic                   period_match_irq_out,
	output logic      [2:0]        channel_match_irq_out
);

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic hit(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] o
	);
		return a == o;
	endfunction

	function automatic logic [2:0] eq3(
		input logic [DATA_W-1:0] v,
		input logic [DATA_W-1:0] c1,
		input logic [DATA_W-1:0] c2,
		input logic [DATA_W-1:0] c3
	);
		return {v == c3, v == c2, v == c1};
	endfunction

	function automatic logic [2:0] lt3(
		input logic [DATA_W-1:0] v,
		input logic [DATA_W-1:0] c1,
		input logic [DATA_W-1:0] c2,
		input logic [DATA_W-1:0] c3
	);
		return {v < c3, v < c2, v < c1};
	endfunction

	// ************************************************************
	// Declarations
	// ************************************************************
	logic                   ce_q;
	logic [CTRL_MODE_W-1:0] mode_q;
	logic [DATA_W-1:0]      cmp_q     [NUM_CMP];
	logic [DATA_W-1:0]      shadow_q  [NUM_CMP];
	logic [DATA_W-1:0]      cmp_use   [NUM_CMP];
	logic [DATA_W-1:0]      next_buf  [NUM_CMP];
	logic [NUM_CMP-1:0]     cmp_wr;
	logic [DATA_W-1:0]      io2_q;
	logic [DATA_W-1:0]      opt0_q;
	logic [DATA_W-1:0]      cnt_q;
	logic [DATA_W-1:0]      cnt_d;
	tmo_state_t             state_q;
	tmo_state_t             state_d;
	logic                   sw_trig_q;
	logic                   trig_prev_q;
	logic                   half_q;
	logic                   half_d;
	logic [2:0]             out_q;
	logic [2:0]             out_d;
	logic                   pirq_q;
	logic                   pirq_d;
	logic [2:0]             cirq_q;
	logic [2:0]             cirq_d;
	logic [DATA_W-1:0]      rd_q;
	logic [DATA_W-1:0]      rd_d;

	logic                   tick;
	logic                   wr_ctrl;
	logic                   ce_rise;
	logic                   wr_os;
	logic                   mode_os;
	logic                   mode_pwm;
	logic                   trig;
	logic                   active;
	logic                   at_period;
	logic                   step;
	logic                   os_stop;
	logic                   reload;
	logic [DATA_W-1:0]      cnt_step;
	logic [2:0]             hits_os;
	logic [2:0]             hits_pwm;
	logic [2:0]             lvl_pwm;
	logic [2:0]             hits_late;
	logic [DATA_W-1:0]      ctrl_rd;
	logic [DATA_W-1:0]      rd_mux;

	// ************************************************************
	// Count clock source
	// ************************************************************
	tmo_tick_if tick_bus (
		.clk (mclk_in)
	);

	tmo_tick_gen u_tick (
		.mclk_in (mclk_in),
		.srst_in (srst_in),
		.tick_if (tick_bus)
	);

	assign tick = tick_bus.tick;

	// ************************************************************
	// Address decode
	// ************************************************************
	assign wr_ctrl  = wr_en_in && hit(addr_in, OFS_CTRL);
	assign ce_rise  = wr_ctrl && wr_data_in[CTRL_CE_BIT] && !ce_q;
	// Mode arrives with the enable bit, so decode the written field
	assign wr_os    =
		(wr_data_in[CTRL_MODE_LSB +: CTRL_MODE_W] == MODE_ONESHOT);
	assign mode_os  = (mode_q == MODE_ONESHOT);
	assign mode_pwm = (mode_q == MODE_PWM);

	for (genvar k = 0; k < NUM_CMP; k++) begin : g_cmp
		assign cmp_wr[k] = wr_en_in &&
			hit(addr_in, OFS_CMP_BASE + ADDR_W'(k));
		// Live compare values
		// One-shot and other modes compare against the written value
		assign cmp_use[k] = mode_pwm ? shadow_q[k] : cmp_q[k];
		assign next_buf[k] = reload ? cmp_q[k] : shadow_q[k];
	end

	// ************************************************************
	// Count sequencing
	// ************************************************************
	// Trigger sources
	assign trig = sw_trig_q || (ext_trigger_in && !trig_prev_q);
	assign active    = (state_q == ST_START) || (state_q == ST_RUN);
	assign at_period = (state_q == ST_RUN) && (cnt_q == cmp_use[0]);
	assign step      = ce_q && tick && active;
	assign os_stop   = mode_os && at_period;
	// First step leaves FFFFH for 0000H
	assign cnt_step  = (state_q == ST_START || at_period) ? CNT_ZERO :
		cnt_q + CNT_ONE;
	assign reload    = mode_pwm && (state_q == ST_START || at_period);

	// Match seen on the new count
	assign hits_os   = eq3(cnt_step, cmp_q[1], cmp_q[2], cmp_q[3]);
	assign hits_pwm  = eq3(cnt_step, next_buf[1], next_buf[2],
		next_buf[3]);
	assign lvl_pwm   = lt3(cnt_step, next_buf[1], next_buf[2],
		next_buf[3]);
	// Late irq on the following count-up
	assign hits_late = (state_q == ST_RUN) ?
		eq3(cnt_q, cmp_q[1], cmp_q[2], cmp_q[3]) : 3'h0;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		half_d  = half_q;
		out_d   = out_q;
		pirq_d  = 1'b0;
		cirq_d  = 3'h0;
		if (ce_rise) begin
			// Counter restarts from full on every enable
			cnt_d   = CNT_FULL;
			out_d   = 3'h0;
			half_d  = 1'b0;
			state_d = wr_os ? ST_WAIT : ST_START;
		end else if (!ce_q) begin
			state_d = ST_IDLE;
			out_d   = 3'h0;
			half_d  = 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					state_d = ST_IDLE;
				end
				ST_WAIT: begin
					half_d = 1'b0;
					if (trig) begin
						state_d = ST_START;
					end
				end
				ST_START, ST_RUN: begin
					if (step && os_stop) begin
						cnt_d   = CNT_FULL;
						out_d   = 3'h0;
						half_d  = 1'b0;
						pirq_d  = 1'b1;
						state_d = ST_WAIT;
					end else if (step) begin
						cnt_d   = cnt_step;
						state_d = ST_RUN;
						pirq_d  = at_period;
						if (mode_os) begin
							out_d  = out_q | hits_os;
							cirq_d = hits_os;
							half_d = 1'b1;
						end else if (mode_pwm) begin
							out_d  = lvl_pwm;
							cirq_d = hits_pwm;
							half_d = half_q ^ at_period;
						end else begin
							cirq_d = hits_late;
						end
					end
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	// Trigger bit is a pulse, so it always reads back as zero
	assign ctrl_rd = {11'h000, 1'b0, mode_q, ce_q};
	assign rd_mux  =
		hit(addr_in, OFS_CTRL)  ? ctrl_rd     :
		hit(addr_in, OFS_COUNT) ? cnt_q       :
		cmp_wr_sel(addr_in)     ? cmp_q[addr_in[1:0] - 2'h2] :
		hit(addr_in, OFS_IO2)   ? io2_q       :
		hit(addr_in, OFS_OPT0)  ? opt0_q      :
		RST_AUX;
	assign rd_d    = rd_en_in ? rd_mux : RST_AUX;

	function automatic logic cmp_wr_sel(
		input logic [ADDR_W-1:0] a
	);
		return (a >= OFS_CMP_BASE) &&
			(a < OFS_CMP_BASE + ADDR_W'(NUM_CMP));
	endfunction

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			ce_q      <= RST_CE;
			mode_q    <= RST_MODE;
			sw_trig_q <= 1'b0;
			io2_q     <= RST_AUX;
			opt0_q    <= RST_AUX;
		end else begin
			sw_trig_q <= wr_ctrl && wr_data_in[CTRL_TRIG_BIT];
			if (wr_ctrl) begin
				ce_q   <= wr_data_in[CTRL_CE_BIT];
				mode_q <= wr_data_in[CTRL_MODE_LSB +: CTRL_MODE_W];
			end
			if (wr_en_in && hit(addr_in, OFS_IO2)) begin
				io2_q <= wr_data_in;
			end
			if (wr_en_in && hit(addr_in, OFS_OPT0)) begin
				opt0_q <= wr_data_in;
			end
		end
	end

	// Compare registers; a write lands in the very next cycle
	always_ff @(posedge mclk_in) begin
		for (int k = 0; k < NUM_CMP; k++) begin
			if (srst_in) begin
				cmp_q[k]    <= RST_CMP;
				shadow_q[k] <= RST_CMP;
			end else begin
				if (cmp_wr[k]) begin
					cmp_q[k] <= wr_data_in;
				end
				if (step && !ce_rise) begin
					shadow_q[k] <= next_buf[k];
				end
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			state_q     <= ST_IDLE;
			cnt_q       <= CNT_FULL;
			half_q      <= 1'b0;
			out_q       <= 3'h0;
			pirq_q      <= 1'b0;
			cirq_q      <= 3'h0;
			rd_q        <= RST_AUX;
			trig_prev_q <= 1'b0;
		end else begin
			state_q     <= state_d;
			cnt_q       <= cnt_d;
			half_q      <= half_d;
			out_q       <= out_d;
			pirq_q      <= pirq_d;
			cirq_q      <= cirq_d;
			rd_q        <= rd_d;
			trig_prev_q <= ext_trigger_in;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign rd_data_out              = rd_q;
	assign half_rate_output_out     = half_q;
	assign channel_pulse_output_out = out_q;
	assign period_match_irq_out     = pirq_q;
	assign channel_match_irq_out    = cirq_q;

endmodule
`default_nettype wire

//--- tmo_pkg.sv
`default_nettype none
package tmo_pkg;

	// ************************************************************
	// Bus geometry
	// ************************************************************
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [ADDR_W-1:0] OFS_CTRL     = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_COUNT    = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_CMP_BASE = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_IO2      = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_OPT0     = 4'h7;
	localparam int                NUM_CMP      = 4;

	// ************************************************************
	// Control register fields
	// ************************************************************
	localparam int CTRL_CE_BIT   = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_MODE_W   = 3;
	localparam int CTRL_TRIG_BIT = 4;

	localparam logic [CTRL_MODE_W-1:0] MODE_ONESHOT = 3'h3;
	localparam logic [CTRL_MODE_W-1:0] MODE_PWM     = 3'h4;

	// ************************************************************
	// Reset values and fixed counts
	// ************************************************************
	localparam logic                   RST_CE    = 1'b0;
	localparam logic [CTRL_MODE_W-1:0] RST_MODE  = 3'h0;
	localparam logic [DATA_W-1:0]      RST_CMP   = 16'h0000;
	localparam logic [DATA_W-1:0]      RST_AUX   = 16'h0000;
	localparam logic [DATA_W-1:0]      CNT_FULL  = 16'hffff;
	localparam logic [DATA_W-1:0]      CNT_ZERO  = 16'h0000;
	localparam logic [DATA_W-1:0]      CNT_ONE   = 16'h0001;

	// ************************************************************
	// Count clock timing
	// ************************************************************
	localparam int                MCLK_NS      = 20;
	localparam int                COUNT_CLK_NS = 40;
	localparam int                DIV_W        = 4;
	localparam logic [DIV_W-1:0]  CNT_DIV      =
		DIV_W'(COUNT_CLK_NS / MCLK_NS);
	localparam logic [DIV_W-1:0]  DIV_ZERO     = 4'h0;
	localparam logic [DIV_W-1:0]  DIV_ONE      = 4'h1;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_START,
		ST_RUN
	} tmo_state_t;

endpackage
`default_nettype wire

//--- tmo_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tmo_tick_if (
	input  wire logic clk
);
	logic tick;

	modport gen  (input clk, output tick);
	modport sink (input clk, input tick);
endinterface
`default_nettype wire

//--- tmo_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module tmo_tick_gen
	import tmo_pkg::*;
(
	input  wire logic   mclk_in,
	input  wire logic   srst_in,
	tmo_tick_if.gen     tick_if
);

	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_d;
	logic             tick_q;
	logic             wrap;

	// ************************************************************
	// Count clock enable
	// ************************************************************
	// A single pulse per count period keeps all logic on one clock
	assign wrap   = (div_q == CNT_DIV - DIV_ONE);
	assign div_d  = wrap ? DIV_ZERO : div_q + DIV_ONE;

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			div_q  <= DIV_ZERO;
			tick_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			tick_q <= wrap;
		end
	end

	assign tick_if.tick = tick_q;

endmodule
`default_nettype wire

//--- tmo_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tmo_timer_chk
	import tmo_pkg::*;
(
	input  wire logic              mclk_in,
	input  wire logic              srst_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] wr_data_in,
	input  wire logic              wr_en_in,
	input  wire logic              rd_en_in,
	input  wire logic [DATA_W-1:0] rd_data_out,
	input  wire logic              ext_trigger_in,
	input  wire logic              half_rate_output_out,
	input  wire logic [2:0]        channel_pulse_output_out,
	input  wire logic              period_match_irq_out,
	input  wire logic [2:0]        channel_match_irq_out
);
	// ****************************************
	// Port relations
	// ****************************************
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (srst_in);

	chk_rd_idle_zero: assert property (
		!$past(rd_en_in) |-> rd_data_out == 16'h0000)
		else $error("read data not zero outside a read slot");
	chk_unmapped_zero: assert property (
		rd_en_in && addr_in > OFS_OPT0 |=> rd_data_out == 16'h0000)
		else $error("unmapped read returned data");
	chk_store_readback: assert property (
		wr_en_in && addr_in >= OFS_CMP_BASE && addr_in <= OFS_OPT0 ##1
		rd_en_in && addr_in == $past(addr_in)
		|=> rd_data_out == $past(wr_data_in, 2))
		else $error("stored register reads back wrong");
	chk_period_irq_pulse: assert property (
		period_match_irq_out |=> !period_match_irq_out)
		else $error("period interrupt longer than one cycle");
	chk_ch_irq_pulse: assert property (
		|channel_match_irq_out |=> channel_match_irq_out == 3'h0)
		else $error("channel interrupt longer than one cycle");
	chk_fall_cause: assert property (
		$fell(channel_pulse_output_out[0])
		|-> period_match_irq_out || channel_match_irq_out[0])
		else $error("channel output fell without a match");
	// Outputs follow the count, which moves once per two cycles
	chk_out_on_tick: assert property (
		$changed(channel_pulse_output_out)
		|=> $stable(channel_pulse_output_out))
		else $error("channel outputs changed off the count clock");
	chk_half_fall: assert property (
		$fell(half_rate_output_out) |-> period_match_irq_out)
		else $error("half rate output fell without period end");
endmodule

bind tmo_timer tmo_timer_chk u_chk (
	.mclk_in                  (mclk_in),
	.srst_in                  (srst_in),
	.addr_in                  (addr_in),
	.wr_data_in               (wr_data_in),
	.wr_en_in                 (wr_en_in),
	.rd_en_in                 (rd_en_in),
	.rd_data_out              (rd_data_out),
	.ext_trigger_in           (ext_trigger_in),
	.half_rate_output_out     (half_rate_output_out),
	.channel_pulse_output_out (channel_pulse_output_out),
	.period_match_irq_out     (period_match_irq_out),
	.channel_match_irq_out    (channel_match_irq_out)
);
`default_nettype wire

//--- tmo_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmo_pin_model (
	input  wire logic        mclk_in,
	input  wire logic        srst_in,
	input  wire logic        fire_in,
	input  wire logic [2:0]  pulse_in,
	input  wire logic        half_in,
	output logic             ext_trigger_out,
	output logic [2:0][15:0] rise_at_out,
	output logic [2:0][15:0] width_out,
	output logic [15:0]      half_width_out
);
	// ****************************************
	// Pin watcher and trigger source
	// ****************************************
	logic        trig_q = 1'b0;
	logic [15:0] cyc_q;
	logic [15:0] half_at_q;
	logic [2:0]  pulse_q;
	logic        half_q;

	assign ext_trigger_out = trig_q;

	// Widths in mclk cycles; a line never raised keeps rise time 0
	always @(posedge mclk_in) begin
		trig_q <= fire_in & ~srst_in;
		if (srst_in) begin
			cyc_q <= 16'h0000;
			pulse_q <= 3'h0;
			half_q <= 1'b0;
			rise_at_out <= '0;
			width_out <= '0;
			half_width_out <= 16'h0000;
		end else begin
			cyc_q <= cyc_q + 16'h0001;
			pulse_q <= pulse_in;
			half_q <= half_in;
			for (int k = 0; k < 3; k++) begin
				if (pulse_in[k] && !pulse_q[k])
					rise_at_out[k] <= cyc_q;
				if (!pulse_in[k] && pulse_q[k])
					width_out[k] <= cyc_q - rise_at_out[k];
			end
			if (half_in && !half_q)
				half_at_q <= cyc_q;
			if (!half_in && half_q)
				half_width_out <= cyc_q - half_at_q;
		end
	end
endmodule
`default_nettype wire

//--- timer_oneshot_and_pwm_modes_tb.sv
`timescale 1ns/1ps
`default_nettype none
module timer_oneshot_and_pwm_modes_tb
	import tmo_pkg::*;
;
	logic              mclk_in    = 1'b0;
	logic              srst_in    = 1'b1;
	logic [ADDR_W-1:0] addr_in    = 4'h0;
	logic [DATA_W-1:0] wr_data_in = 16'h0000;
	logic              wr_en_in   = 1'b0;
	logic              rd_en_in   = 1'b0;
	logic [DATA_W-1:0] rd_data_out;
	logic              ext_trigger_in;
	logic              half_rate_output_out;
	logic [2:0]        channel_pulse_output_out;
	logic              period_match_irq_out;
	logic [2:0]        channel_match_irq_out;
	logic              fire       = 1'b0;
	logic [2:0][15:0]  rise_at;
	logic [2:0][15:0]  width;
	logic [15:0]       half_width;
	logic [15:0]       last_rd;
	logic [15:0]       rv;
	logic [31:0]       ent;
	logic              rd_seen    = 1'b0;
	logic [31:0]       exp_q[$];
	int                error_cnt  = 0;
	int                n_tests    = 0;
	int                seed       = 32'h1b5eeea5;
	logic [15:0]       cyc        = 16'h0000;
	logic [15:0]       pirq_at    = 16'h0000;
	logic [15:0]       cirq_at    = 16'h0000;
	logic [15:0]       irq1_n     = 16'h0000;
	logic [15:0]       irq1_on    = 16'h0000;

	always #10 mclk_in = ~mclk_in;

	tmo_timer DUT (
		.mclk_in                  (mclk_in),
		.srst_in                  (srst_in),
		.addr_in                  (addr_in),
		.wr_data_in               (wr_data_in),
		.wr_en_in                 (wr_en_in),
		.rd_en_in                 (rd_en_in),
		.rd_data_out              (rd_data_out),
		.ext_trigger_in           (ext_trigger_in),
		.half_rate_output_out     (half_rate_output_out),
		.channel_pulse_output_out (channel_pulse_output_out),
		.period_match_irq_out     (period_match_irq_out),
		.channel_match_irq_out    (channel_match_irq_out)
	);

	tmo_pin_model u_pins (
		.mclk_in         (mclk_in),
		.srst_in         (srst_in),
		.fire_in         (fire),
		.pulse_in        (channel_pulse_output_out),
		.half_in         (half_rate_output_out),
		.ext_trigger_out (ext_trigger_in),
		.rise_at_out     (rise_at),
		.width_out       (width),
		.half_width_out  (half_width)
	);

	// ****************************************
	// Bus tasks and scoreboard
	// ****************************************
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("checks=%0d errors=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_en_in <= 1'b1;
		@(posedge mclk_in);
		wr_en_in <= 1'b0;
	endtask

	// Mask 0 only captures the value into last_rd
	task automatic rd(input logic [3:0] a, input logic [15:0] e,
		input logic [15:0] m);
		@(posedge mclk_in);
		addr_in <= a;
		rd_en_in <= 1'b1;
		exp_q.push_back({m, e});
		@(posedge mclk_in);
		rd_en_in <= 1'b0;
	endtask

	// Write then read with no gap between the strobes
	task automatic wr_rd(input logic [3:0] a, input logic [15:0] d);
		wr(a, d);
		rd_en_in <= 1'b1;
		exp_q.push_back({16'hffff, d});
		@(posedge mclk_in);
		rd_en_in <= 1'b0;
	endtask

	task automatic rst();
		@(posedge mclk_in);
		srst_in <= 1'b1;
		repeat (16) @(posedge mclk_in);
		srst_in <= 1'b0;
	endtask

	task automatic cfg(input logic [15:0] d0, d1, d2, d3);
		wr(OFS_CMP_BASE, d0);
		wr(OFS_CMP_BASE + 4'h1, d1);
		wr(OFS_CMP_BASE + 4'h2, d2);
		wr(OFS_CMP_BASE + 4'h3, d3);
	endtask

	task automatic wait_end();
		int i;
		i = 0;
		while (period_match_irq_out !== 1'b1 && i < 200) begin
			@(negedge mclk_in);
			i++;
		end
		if (period_match_irq_out !== 1'b1) begin
			// A missing period end is a mismatch and ends the run
			error_cnt++;
			close_out();
		end
	endtask

	function automatic logic [15:0] ctl(input logic [2:0] md,
		input logic ce, input logic tg);
		ctl = (16'(md) << CTRL_MODE_LSB) | (16'(ce) << CTRL_CE_BIT)
			| (16'(tg) << CTRL_TRIG_BIT);
	endfunction

	always @(posedge mclk_in) begin
		if (rd_seen) begin
			if (exp_q.size() == 0) begin
				cmp(rd_data_out, 16'hdead);
			end else begin
				ent = exp_q.pop_front();
				last_rd = rd_data_out;
				if (ent[31:16] != 16'h0000)
					cmp(rd_data_out & ent[31:16], ent[15:0]);
			end
		end
		rd_seen <= rd_en_in;
	end

	// Channel 1 interrupt stamps and counts for the timing checks
	always @(posedge mclk_in) begin
		cyc <= cyc + 16'h0001;
		if (srst_in) begin
			irq1_n  <= 16'h0000;
			irq1_on <= 16'h0000;
		end else if (channel_match_irq_out[0]) begin
			cirq_at <= cyc;
			irq1_n  <= irq1_n + 16'h0001;
			if (channel_pulse_output_out[0])
				irq1_on <= irq1_on + 16'h0001;
		end
		if (period_match_irq_out)
			pirq_at <= cyc;
	end

	// A hang still reaches the closing report
	initial begin
		repeat (20000) @(posedge mclk_in);
		error_cnt++;
		close_out();
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		rst();
		for (int i = 0; i < 8; i++)
			rd(4'(i), (i == 1) ? CNT_FULL : RST_CMP, 16'hffff);
		rd(4'h9, 16'h0000, 16'hffff);
		wr(OFS_CMP_BASE, CNT_FULL);
		wr(OFS_CTRL, ctl(MODE_PWM, 1'b1, 1'b0));
		repeat (2) @(posedge mclk_in);
		rd(OFS_COUNT, CNT_ZERO, 16'hfffe);
		repeat (2) @(posedge mclk_in);
		rd(OFS_COUNT, 16'h0000, 16'h0000);
		repeat (2) @(posedge mclk_in);
		rd(OFS_COUNT, last_rd + 16'h0002, 16'hffff);
		wr(OFS_CTRL, ctl(MODE_PWM, 1'b0, 1'b0));
		repeat (4) @(posedge mclk_in);
		rd(OFS_COUNT, 16'h0000, 16'h0000);
		repeat (8) @(posedge mclk_in);
		rd(OFS_COUNT, last_rd, 16'hffff);

		rst();
		cfg(16'h0005, 16'h0002, 16'h0000, 16'h0006);
		wr(OFS_CTRL, ctl(MODE_PWM, 1'b1, 1'b0));
		repeat (40) @(negedge mclk_in);
		cmp(width[0], 16'd4);
		cmp(half_width, 16'd12);
		cmp(rise_at[1], 16'h0000);
		cmp({15'h0, channel_pulse_output_out[2]}, 16'h0001);
		rv = {14'h0, 2'($random(seed))} + 16'h0001;
		wr(OFS_CMP_BASE + 4'h1, rv);
		repeat (40) @(negedge mclk_in);
		cmp(width[0], rv << 1);

		rst();
		// compares set while the counter is stopped
		cfg(16'h0004, 16'h0001, 16'h0004, 16'h0005);
		rv = 16'($random(seed));
		wr_rd(OFS_IO2, rv);
		wr_rd(OFS_OPT0, ~rv);
		wr(OFS_CTRL, ctl(MODE_ONESHOT, 1'b1, 1'b0));
		repeat (12) @(posedge mclk_in);
		rd(OFS_COUNT, CNT_FULL, 16'hffff);
		@(posedge mclk_in);
		fire <= 1'b1;
		repeat (2) @(posedge mclk_in);
		fire <= 1'b0;
		repeat (4) @(posedge mclk_in);
		wr(OFS_CTRL, ctl(MODE_ONESHOT, 1'b1, 1'b1));
		wait_end();
		repeat (4) @(negedge mclk_in);
		cmp(width[0], 16'd8);
		cmp(irq1_n, 16'h0001);
		cmp(irq1_on, 16'h0001);
		cmp(width[1], 16'd2);
		cmp(rise_at[1] - rise_at[0], 16'd6);
		cmp(rise_at[2], 16'h0000);
		rd(OFS_COUNT, CNT_FULL, 16'hffff);
		wr(OFS_CTRL, ctl(MODE_ONESHOT, 1'b1, 1'b1));
		wait_end();
		repeat (4) @(negedge mclk_in);
		cmp(rise_at[1] - rise_at[0], 16'd6);
		rd(OFS_COUNT, CNT_FULL, 16'hffff);

		rst();
		// Mode zero is the plain interval mode
		cfg(16'h0003, 16'h0001, 16'h0000, 16'h0000);
		wr(OFS_CTRL, ctl(RST_MODE, 1'b1, 1'b0));
		wait_end();
		repeat (6) @(negedge mclk_in);
		// Match at count 1 shows two ticks after the clear, one tick late
		cmp(cirq_at - pirq_at, 16'd4);
		cmp(irq1_on, 16'h0000);
		cmp(irq1_n, 16'h0002);
		repeat (4) @(posedge mclk_in);
		close_out();
	end
endmodule
`default_nettype wire
